/* dtbam_pkg.sv */
// Package: constants and types for the data transfer bus master controller
package dtbam_pkg;
	// ------------------------------------------------------------
	// Address modifier codes
	// ------------------------------------------------------------
	localparam logic [5:0] AM_STD_SUP_ASC = 6'h3F;
	localparam logic [5:0] AM_STD_SUP_PRG = 6'h3E;
	localparam logic [5:0] AM_STD_SUP_DAT = 6'h3D;
	localparam logic [5:0] AM_STD_NP_ASC = 6'h3B;
	localparam logic [5:0] AM_STD_NP_PRG = 6'h3A;
	localparam logic [5:0] AM_STD_NP_DAT = 6'h39;
	localparam logic [5:0] AM_SHT_SUP_IO = 6'h2D;
	localparam logic [5:0] AM_SHT_NP_IO = 6'h29;
	localparam logic [5:0] AM_EXT_SUP_ASC = 6'h0F;
	localparam logic [5:0] AM_EXT_SUP_PRG = 6'h0E;
	localparam logic [5:0] AM_EXT_SUP_DAT = 6'h0D;
	localparam logic [5:0] AM_EXT_NP_ASC = 6'h0B;
	localparam logic [5:0] AM_EXT_NP_PRG = 6'h0A;
	localparam logic [5:0] AM_EXT_NP_DAT = 6'h09;
	localparam logic [5:0] AM_USER_LO = 6'h10;
	localparam logic [5:0] AM_USER_HI = 6'h1F;

	// ------------------------------------------------------------
	// Widths and address masks
	// ------------------------------------------------------------
	localparam int AW = 31;
	localparam int DW = 32;
	localparam logic [AW-1:0] MASK_A16 = 31'h00007FFF;
	localparam logic [AW-1:0] MASK_A24 = 31'h007FFFFF;
	localparam logic [AW-1:0] MASK_A32 = 31'h7FFFFFFF;
	localparam logic [AW-1:0] ADDR_ZERO = 31'h00000000;
	localparam logic [DW-1:0] DATA_ZERO = 32'h00000000;
	localparam logic [5:0] AM_ZERO = 6'h00;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0]
	{
		DTBAM_CLS_SPEC = 2'h0,
		DTBAM_CLS_USER = 2'h1,
		DTBAM_CLS_RSVD = 2'h2
	} dtbam_class_t;

	typedef enum logic [1:0]
	{
		DTBAM_W_SHORT = 2'h0,
		DTBAM_W_STD = 2'h1,
		DTBAM_W_EXT = 2'h2,
		DTBAM_W_NONE = 2'h3
	} dtbam_width_t;

	typedef enum logic [2:0]
	{
		DTBAM_IDLE = 3'h0,
		DTBAM_SETUP = 3'h1,
		DTBAM_STROBE = 3'h2,
		DTBAM_RELEASE = 3'h3,
		DTBAM_ERROR = 3'h4
	} dtbam_state_t;
endpackage

/* dtbam_am_if.sv */
// Interface: decoded address modifier fields between decoder and master
`timescale 1ns/1ns
interface dtbam_am_if;
	logic [5:0] am;
	dtbam_pkg::dtbam_class_t cls;
	dtbam_pkg::dtbam_width_t width;
	logic superv;
	logic ascend;
	logic legal;

	modport dec
	(
		input am,
		output cls,
		output width,
		output superv,
		output ascend,
		output legal
	);
	modport user
	(
		output am,
		input cls,
		input width,
		input superv,
		input ascend,
		input legal
	);
endinterface

/* dtbam_am_dec.sv */
// Module: combinational address modifier code classifier
`timescale 1ns/1ns
module dtbam_am_dec
(
	dtbam_am_if.dec amb // Modifier code in, decoded fields out
);
	// ------------------------------------------------------------
	// Classification
	// ------------------------------------------------------------
	// Sort every one of the 64 codes into spec, user or reserved
	always_comb
	begin
		amb.cls = dtbam_pkg::DTBAM_CLS_RSVD;
		amb.width = dtbam_pkg::DTBAM_W_NONE;
		amb.superv = 1'b0;
		amb.ascend = 1'b0;
		case (amb.am)
			dtbam_pkg::AM_STD_SUP_ASC, dtbam_pkg::AM_STD_SUP_PRG,
			dtbam_pkg::AM_STD_SUP_DAT:
			begin
				amb.cls = dtbam_pkg::DTBAM_CLS_SPEC;
				amb.width = dtbam_pkg::DTBAM_W_STD;
				amb.superv = 1'b1;
				amb.ascend = (amb.am == dtbam_pkg::AM_STD_SUP_ASC);
			end
			dtbam_pkg::AM_STD_NP_ASC, dtbam_pkg::AM_STD_NP_PRG,
			dtbam_pkg::AM_STD_NP_DAT:
			begin
				amb.cls = dtbam_pkg::DTBAM_CLS_SPEC;
				amb.width = dtbam_pkg::DTBAM_W_STD;
				amb.ascend = (amb.am == dtbam_pkg::AM_STD_NP_ASC);
			end
			dtbam_pkg::AM_SHT_SUP_IO, dtbam_pkg::AM_SHT_NP_IO:
			begin
				amb.cls = dtbam_pkg::DTBAM_CLS_SPEC;
				amb.width = dtbam_pkg::DTBAM_W_SHORT;
				amb.superv = (amb.am == dtbam_pkg::AM_SHT_SUP_IO);
			end
			dtbam_pkg::AM_EXT_SUP_ASC, dtbam_pkg::AM_EXT_SUP_PRG,
			dtbam_pkg::AM_EXT_SUP_DAT:
			begin
				amb.cls = dtbam_pkg::DTBAM_CLS_SPEC;
				amb.width = dtbam_pkg::DTBAM_W_EXT;
				amb.superv = 1'b1;
				amb.ascend = (amb.am == dtbam_pkg::AM_EXT_SUP_ASC);
			end
			dtbam_pkg::AM_EXT_NP_ASC, dtbam_pkg::AM_EXT_NP_PRG,
			dtbam_pkg::AM_EXT_NP_DAT:
			begin
				amb.cls = dtbam_pkg::DTBAM_CLS_SPEC;
				amb.width = dtbam_pkg::DTBAM_W_EXT;
				amb.ascend = (amb.am == dtbam_pkg::AM_EXT_NP_ASC);
			end
			default:
			begin
				if (amb.am >= dtbam_pkg::AM_USER_LO && amb.am <= dtbam_pkg::AM_USER_HI)
				begin
					amb.cls = dtbam_pkg::DTBAM_CLS_USER;
				end
			end
		endcase
	end

	// User codes are legal for local use; reserved codes are never issued
	assign amb.legal = (amb.cls != dtbam_pkg::DTBAM_CLS_RSVD);
endmodule

/* dtbam_master.sv */
// Module: bus master driving address, modifier and strobes with interlocked release
`timescale 1ns/1ns
// ------------------------------------------------------------
// Function
// - Drive A01..A15, A01..A23 or A01..A31 by address width of the code
// - All six modifier lines are driven on every transfer
// - No A00 line; word address on A01 up, bytes picked by strobes
// - Write: present address, modifier, data, then drop address and data strobes
// - Read: present address and modifier, data undriven, then drop strobes
// - Master holds strobes until acknowledge or bus error arrives
// - Read data captured only on acknowledge, never on bus error
// - Bus error leads to error handling, otherwise next cycle may start
// - Standard supervisory: 3F ascending, 3E program, 3D data
// - Standard non-privileged: 3B ascending, 3A program, 39 data
// - Short I/O: 2D supervisory, 29 non-privileged
// - Extended supervisory: 0F ascending, 0E program, 0D data
// - Extended non-privileged: 0B ascending, 0A program, 09 data
// - 64 codes are spec, user 10..1F, or reserved without function
// - Odd strobe selects D00..D07, even strobe D08..D15, replacing A00
// ------------------------------------------------------------
module dtbam_master
(
	input wire logic clock, // System clock
	input wire logic arst_n, // Asynchronous reset, active low
	input wire logic req_valid, // Request a transfer, level
	input wire logic req_write, // 1 write, 0 read
	input wire logic [5:0] req_am, // Modifier code to issue
	input wire logic [30:0] req_addr, // Word address A01..A31 in bits 0..30
	input wire logic req_lword, // Longword transfer
	input wire logic req_odd_en, // Odd byte lane wanted
	input wire logic req_even_en, // Even byte lane wanted
	input wire logic [31:0] req_wdata, // Write data
	input wire logic err_clear, // Leave error handling, pulse
	output logic req_ready, // Ready to take a request
	output logic done, // Cycle finished, one cycle pulse
	output logic done_err, // Finished cycle ended in bus error
	output logic reject, // Request refused, high each cycle a refused request is held
	output logic err_hold, // In error handling
	output logic [31:0] rdata, // Captured read data
	output logic [30:0] bus_addr, // Address lines A01..A31
	output logic [5:0] bus_am, // Modifier lines
	output logic bus_as_n, // Address strobe
	output logic bus_ds0_n, // Odd byte strobe
	output logic bus_ds1_n, // Even byte strobe
	output logic bus_lword_n, // Longword select
	output logic bus_write_n, // Read/write select
	output logic bus_iack_n, // Interrupt acknowledge, held high
	output logic [31:0] bus_d_o, // Data out
	output logic bus_d_oe, // Data drive enable
	input wire logic [31:0] bus_d_i, // Data in
	input wire logic bus_dtack_n, // Data acknowledge from slave
	input wire logic bus_berr_n // Bus error from slave
);
	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	dtbam_am_if amb ();
	dtbam_pkg::dtbam_state_t state_q;
	logic accept;
	logic [30:0] addr_mask;
	logic answered;
	logic req_odd_en_q;
	logic req_even_en_q;

	// Masks the word address to the width of the modifier code
	function automatic logic [30:0] width_mask(input dtbam_pkg::dtbam_width_t w);
		case (w)
			dtbam_pkg::DTBAM_W_SHORT: width_mask = dtbam_pkg::MASK_A16;
			dtbam_pkg::DTBAM_W_STD: width_mask = dtbam_pkg::MASK_A24;
			default: width_mask = dtbam_pkg::MASK_A32;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Modifier decode
	// ------------------------------------------------------------
	assign amb.am = req_am;
	dtbam_am_dec u_dec
	(
		.amb(amb)
	);

	// Legal code and at least one strobe wanted; reserved codes refused
	assign accept = req_valid && (state_q == dtbam_pkg::DTBAM_IDLE) && amb.legal
		&& (req_odd_en || req_even_en);
	assign addr_mask = width_mask(amb.width);
	assign answered = !bus_dtack_n || !bus_berr_n;

	// ------------------------------------------------------------
	// Cycle sequencer
	// ------------------------------------------------------------
	// Interlocked master cycle
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q <= dtbam_pkg::DTBAM_IDLE;
		end
		else
		begin
			case (state_q)
				dtbam_pkg::DTBAM_IDLE:
					if (accept)
						state_q <= dtbam_pkg::DTBAM_SETUP;
				dtbam_pkg::DTBAM_SETUP:
					state_q <= dtbam_pkg::DTBAM_STROBE;
				dtbam_pkg::DTBAM_STROBE:
					if (answered)
						state_q <= dtbam_pkg::DTBAM_RELEASE;
				dtbam_pkg::DTBAM_RELEASE:
					if (bus_dtack_n && bus_berr_n)
						state_q <= bus_write_n ? dtbam_pkg::DTBAM_IDLE : dtbam_pkg::DTBAM_IDLE;
				dtbam_pkg::DTBAM_ERROR:
					if (err_clear)
						state_q <= dtbam_pkg::DTBAM_IDLE;
				default:
					state_q <= dtbam_pkg::DTBAM_IDLE;
			endcase
			if (state_q == dtbam_pkg::DTBAM_RELEASE && bus_dtack_n && bus_berr_n && done_err)
				state_q <= dtbam_pkg::DTBAM_ERROR;
		end
	end

	// ------------------------------------------------------------
	// Address, modifier and control lines
	// ------------------------------------------------------------
	// Latch address and code at request; all six modifier lines driven
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			bus_addr <= dtbam_pkg::ADDR_ZERO;
			bus_am <= dtbam_pkg::AM_ZERO;
			bus_lword_n <= 1'b1;
			bus_write_n <= 1'b1;
			bus_iack_n <= 1'b1;
		end
		else if (accept)
		begin
			bus_addr <= req_addr & addr_mask;
			bus_am <= req_am;
			bus_lword_n <= !req_lword;
			bus_write_n <= !req_write;
			bus_iack_n <= 1'b1;
		end
	end

	// Strobes fall one cycle after address settles, rise after the answer
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			bus_as_n <= 1'b1;
			bus_ds0_n <= 1'b1;
			bus_ds1_n <= 1'b1;
		end
		else if (state_q == dtbam_pkg::DTBAM_SETUP)
		begin
			bus_as_n <= 1'b0;
			bus_ds0_n <= !(req_odd_en_q || bus_lword_n == 1'b0);
			bus_ds1_n <= !(req_even_en_q || bus_lword_n == 1'b0);
		end
		else if (state_q == dtbam_pkg::DTBAM_STROBE && answered)
		begin
			bus_as_n <= 1'b1;
			bus_ds0_n <= 1'b1;
			bus_ds1_n <= 1'b1;
		end
	end

	// Lane choice held from request to strobe
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			req_odd_en_q <= 1'b0;
			req_even_en_q <= 1'b0;
		end
		else if (accept)
		begin
			req_odd_en_q <= req_odd_en;
			req_even_en_q <= req_even_en;
		end
	end

	// ------------------------------------------------------------
	// Data lines
	// ------------------------------------------------------------
	// Write data driven from request until the slave releases acknowledge and bus error
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			bus_d_o <= dtbam_pkg::DATA_ZERO;
			bus_d_oe <= 1'b0;
		end
		else if (accept)
		begin
			bus_d_o <= req_wdata;
			bus_d_oe <= req_write;
		end
		else if (state_q == dtbam_pkg::DTBAM_RELEASE && bus_dtack_n && bus_berr_n)
		begin
			bus_d_oe <= 1'b0;
		end
	end

	// Read data taken only on acknowledge
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			rdata <= dtbam_pkg::DATA_ZERO;
		else if (state_q == dtbam_pkg::DTBAM_STROBE && !bus_dtack_n && bus_berr_n && bus_write_n)
			rdata <= bus_d_i;
	end

	// ------------------------------------------------------------
	// User status
	// ------------------------------------------------------------
	// Completion, error and refusal flags
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			done <= 1'b0;
			done_err <= 1'b0;
			reject <= 1'b0;
			req_ready <= 1'b0;
			err_hold <= 1'b0;
		end
		else
		begin
			done <= state_q == dtbam_pkg::DTBAM_RELEASE && bus_dtack_n && bus_berr_n;
			if (state_q == dtbam_pkg::DTBAM_STROBE && answered)
				done_err <= !bus_berr_n;
			reject <= req_valid && (state_q == dtbam_pkg::DTBAM_IDLE) && !accept;
			req_ready <= (state_q == dtbam_pkg::DTBAM_IDLE) && !accept;
			err_hold <= (state_q == dtbam_pkg::DTBAM_ERROR && !err_clear)
				|| (state_q == dtbam_pkg::DTBAM_RELEASE && bus_dtack_n && bus_berr_n && done_err);
		end
	end
endmodule

/* dtbam_monitor.sv */
// Checker: protocol properties at the master's ports
`timescale 1ns/1ns
module dtbam_checker
(
	input wire logic clock, // Clock
	input wire logic arst_n, // Reset
	input wire logic done, // Cycle end
	input wire logic done_err, // Error result
	input wire logic err_hold, // Error state
	input wire logic [31:0] rdata, // Read data
	input wire logic [30:0] bus_addr, // Address
	input wire logic [5:0] bus_am, // Modifier
	input wire logic bus_as_n, // Strobe
	input wire logic bus_ds0_n, // Odd strobe
	input wire logic bus_ds1_n, // Even strobe
	input wire logic bus_lword_n, // Longword
	input wire logic bus_write_n, // Direction
	input wire logic bus_iack_n, // Iack line
	input wire logic bus_d_oe, // Data enable
	input wire logic bus_dtack_n, // Acknowledge
	input wire logic bus_berr_n // Bus error
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!arst_n);

	AST_IACK_HIGH: assert property (bus_iack_n)
		else $error("iack driven low");
	AST_HOLD_WAIT: assert property (!bus_as_n && bus_dtack_n && bus_berr_n |=> !bus_as_n)
		else $error("strobe released early");
	AST_RELEASE: assert property (!bus_as_n && !bus_dtack_n |-> ##[1:2] bus_as_n && bus_ds0_n && bus_ds1_n)
		else $error("strobes not released");
	AST_ADDR_STABLE: assert property (!bus_as_n |=> bus_as_n || ($stable(bus_addr) && $stable(bus_am) && $stable(bus_write_n)))
		else $error("address moved in cycle");
	AST_SHORT_MASK: assert property (!bus_as_n && bus_am[5:4] == 2'h2 |-> bus_addr[30:15] == 16'h0000)
		else $error("short address too wide");
	AST_WRITE_OE: assert property (!bus_as_n && !bus_write_n |-> bus_d_oe)
		else $error("write data not driven");
	AST_READ_OE: assert property (!bus_as_n && bus_write_n |-> !bus_d_oe)
		else $error("data driven on read");
	AST_LWORD_LANES: assert property (!bus_as_n && !bus_lword_n |-> !bus_ds0_n && !bus_ds1_n)
		else $error("longword lacks a strobe");
	AST_ERR_HOLD: assert property (done && done_err |-> ##[0:1] err_hold)
		else $error("no error handling");
	AST_RD_BERR: assert property (!bus_berr_n |=> $stable(rdata))
		else $error("data taken on bus error");
endmodule
bind dtbam_master dtbam_checker dtbam_checker_inst
(
	.clock(clock), .arst_n(arst_n), .done(done), .done_err(done_err), .err_hold(err_hold),
	.rdata(rdata), .bus_addr(bus_addr), .bus_am(bus_am), .bus_as_n(bus_as_n),
	.bus_ds0_n(bus_ds0_n), .bus_ds1_n(bus_ds1_n), .bus_lword_n(bus_lword_n),
	.bus_write_n(bus_write_n), .bus_iack_n(bus_iack_n), .bus_d_oe(bus_d_oe),
	.bus_dtack_n(bus_dtack_n), .bus_berr_n(bus_berr_n)
);

/* dtbam_slave_model.sv */
// Partner model: behavioural slave answering the master
`timescale 1ns/1ns
module dtbam_slave_model
(
	input wire logic clock, // Clock
	input wire logic [63:0] accept, // Codes answered
	input wire logic [3:0] delay, // Latency
	input wire logic [30:0] addr, // Address
	input wire logic [5:0] am, // Modifier
	input wire logic as_n, // Strobe
	input wire logic ds0_n, // Odd strobe
	input wire logic ds1_n, // Even strobe
	input wire logic lword_n, // Longword
	input wire logic write_n, // Direction
	input wire logic iack_n, // Iack line
	input wire logic [31:0] d_i, // Data in
	output logic [31:0] d_o, // Data out
	output logic dtack_n, // Acknowledge
	output logic berr_n // Bus error
);
	logic [31:0] mem [0:63];
	logic [30:0] a;
	logic [3:0] cnt_q;
	logic hit;
	logic asc;
	logic [5:0] seq_q;
	logic [5:0] idx;

	// Start with answer lines released
	initial
	begin
		d_o = 32'h00000000;
		dtack_n = 1'b1;
		berr_n = 1'b1;
		cnt_q = 4'h0;
		seq_q = 6'h00;
	end

	// Decode window by code group
	always_comb
	begin
		case (am[5:4])
			2'h2: a = addr & dtbam_pkg::MASK_A16;
			2'h3: a = addr & dtbam_pkg::MASK_A24;
			default: a = addr;
		endcase
		hit = !as_n && iack_n && accept[am] && a[30:7] == 24'h000000;
		asc = am == dtbam_pkg::AM_STD_SUP_ASC || am == dtbam_pkg::AM_STD_NP_ASC
			|| am == dtbam_pkg::AM_EXT_SUP_ASC || am == dtbam_pkg::AM_EXT_NP_ASC;
		idx = asc ? seq_q : a[5:0];
	end

	// Answer after the latency and hold until both data strobes rise
	always @(posedge clock)
		if (ds0_n && ds1_n)
		begin
			cnt_q <= 4'h0;
			seq_q <= a[5:0];
			dtack_n <= 1'b1;
			berr_n <= 1'b1;
			d_o <= ~d_o;
		end
		else if (hit && dtack_n && berr_n)
		begin
			d_o <= ~d_o;
			if (cnt_q != delay)
				cnt_q <= cnt_q + 4'h1;
			else if (a[6] && (!write_n || a[5]))
				berr_n <= 1'b0;
			else
			begin
				dtack_n <= 1'b0;
				seq_q <= seq_q + 6'h01;
				if (write_n)
					d_o <= mem[idx];
				else if (!lword_n)
					mem[idx] <= d_i;
				else
				begin
					if (!ds0_n) mem[idx][7:0] <= d_i[7:0];
					if (!ds1_n) mem[idx][15:8] <= d_i[15:8];
				end
			end
		end
		else if (!hit || !berr_n || !write_n)
			d_o <= ~d_o;
endmodule

/* dtbam_master_test.sv */
// Testbench: master controller against the slave model
`timescale 1ns/1ns
module dtbam_master_test;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic req_lword = 1'b0;
	logic req_odd_en = 1'b0;
	logic req_even_en = 1'b0;
	logic err_clear = 1'b0;
	logic [5:0] req_am = 6'h00;
	logic [30:0] req_addr = 31'h00000000;
	logic [31:0] req_wdata = 32'h00000000;
	logic [63:0] accept = '1;
	logic [3:0] delay = 4'h0;
	logic req_ready, done, done_err, reject, err_hold, bus_as_n, bus_ds0_n, bus_ds1_n;
	logic bus_lword_n, bus_write_n, bus_iack_n, bus_d_oe, bus_dtack_n, bus_berr_n;
	logic [31:0] rdata, bus_d_o, slv_d, bus_d, wd, wd2, lastrd;
	logic [30:0] bus_addr, hi;
	logic [5:0] bus_am;
	logic [15:0] seed = 16'h5232;
	logic [34:0] notes [$];
	logic [34:0] e, got;
	logic [5:0] codes [15] = '{6'h3F, 6'h3E, 6'h3D, 6'h3B, 6'h3A, 6'h39, 6'h2D, 6'h29,
		6'h0F, 6'h0E, 6'h0D, 6'h0B, 6'h0A, 6'h09, 6'h15};
	logic [5:0] bad [5] = '{6'h3C, 6'h38, 6'h2F, 6'h00, 6'h08};
	int err_total = 0;
	int checked = 0;

	// Clock and data wire resolution
	always #10 clock = ~clock;
	assign bus_d = bus_d_oe ? bus_d_o : slv_d;

	dtbam_master dtbam_master_inst
	(
		.clock(clock), .arst_n(arst_n), .req_valid(req_valid), .req_write(req_write),
		.req_am(req_am), .req_addr(req_addr), .req_lword(req_lword), .req_odd_en(req_odd_en),
		.req_even_en(req_even_en), .req_wdata(req_wdata), .err_clear(err_clear),
		.req_ready(req_ready), .done(done), .done_err(done_err), .reject(reject),
		.err_hold(err_hold), .rdata(rdata), .bus_addr(bus_addr), .bus_am(bus_am),
		.bus_as_n(bus_as_n), .bus_ds0_n(bus_ds0_n), .bus_ds1_n(bus_ds1_n),
		.bus_lword_n(bus_lword_n), .bus_write_n(bus_write_n), .bus_iack_n(bus_iack_n),
		.bus_d_o(bus_d_o), .bus_d_oe(bus_d_oe), .bus_d_i(bus_d), .bus_dtack_n(bus_dtack_n),
		.bus_berr_n(bus_berr_n)
	);
	dtbam_slave_model dtbam_slave_model_inst
	(
		.clock(clock), .accept(accept), .delay(delay), .addr(bus_addr), .am(bus_am),
		.as_n(bus_as_n), .ds0_n(bus_ds0_n), .ds1_n(bus_ds1_n), .lword_n(bus_lword_n),
		.write_n(bus_write_n), .iack_n(bus_iack_n), .d_i(bus_d), .d_o(slv_d),
		.dtack_n(bus_dtack_n), .berr_n(bus_berr_n)
	);

	// Pseudo-random step
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// Counted comparison
	task automatic chk(input string nm, input logic [34:0] x, input logic [34:0] y);
		checked++;
		if (x !== y)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, x, y);
		end
	endtask

	// Verdict and end of run
	task automatic summarize();
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Issue one request, note its result and wait for the outcome
	task automatic go(input logic w, input logic [5:0] am, input logic [30:0] a,
		input logic [2:0] ln, input logic [31:0] d, input logic [34:0] x, input logic quiet);
		int n;
		n = 0;
		while (req_ready !== 1'b1 && n < 60)
		begin
			@(negedge clock);
			n++;
		end
		if (!quiet)
			notes.push_back(x);
		{req_write, req_am, req_addr, req_lword, req_odd_en, req_even_en, req_wdata} = {w, am, a, ln, d};
		req_valid = 1'b1;
		@(negedge clock);
		req_valid = 1'b0;
		while (done !== 1'b1 && reject !== 1'b1 && n < 60)
		begin
			@(negedge clock);
			n++;
		end
		chk("silence", {34'h0, quiet}, {34'h0, n == 60});
		if (n == 60 && !quiet)
			summarize();
		// Let an edge pass so the next request never re-raises valid in this step
		@(negedge clock);
	endtask

	// Leave error handling
	task automatic clr();
		err_clear = 1'b1;
		@(negedge clock);
		err_clear = 1'b0;
		@(negedge clock);
	endtask

	// Compare each finished or refused request with the oldest note
	always @(negedge clock)
		if (done === 1'b1 || reject === 1'b1)
		begin
			e = (notes.size() > 0) ? notes.pop_front() : 35'h7FFFFFFFF;
			got = {reject ? 2'h2 : {1'b0, done_err}, e[32], e[32] ? rdata : 32'h00000000};
			chk("result", e, got);
		end

	// Main sequence
	initial
	begin
		repeat (4) @(negedge clock);
		arst_n = 1'b1;
		foreach (codes[i])
		begin
			seed = lfsr(seed);
			wd = {seed, ~seed};
			hi = {seed[14:0], seed};
			case (codes[i][5:4])
				2'h2: hi = hi & ~dtbam_pkg::MASK_A16;
				2'h3: hi = hi & ~dtbam_pkg::MASK_A24;
				default: hi = 31'h00000000;
			endcase
			delay = 4'(i % 4);
			go(1'b1, codes[i], hi | 31'(2 * i), 3'h7, wd, 35'h0, 1'b0);
			go(1'b0, codes[i], hi | 31'(2 * i), 3'h7, 32'h0, {3'h1, wd}, 1'b0);
		end
		seed = lfsr(seed);
		wd = {~seed, seed};
		wd2 = {seed, 16'h5AC3};
		go(1'b1, 6'h3D, 31'h00000030, 3'h7, wd, 35'h0, 1'b0);
		go(1'b1, 6'h3D, 31'h00000030, 3'h2, wd2, 35'h0, 1'b0);
		go(1'b1, 6'h3D, 31'h00000030, 3'h1, ~wd2, 35'h0, 1'b0);
		lastrd = {wd[31:16], ~wd2[15:8], wd2[7:0]};
		go(1'b0, 6'h3D, 31'h00000030, 3'h7, 32'h0, {3'h1, lastrd}, 1'b0);
		foreach (bad[i])
			go(1'b0, bad[i], 31'h00000000, 3'h7, 32'h0, 35'h400000000, 1'b0);
		go(1'b0, 6'h3D, 31'h00000000, 3'h0, 32'h0, 35'h400000000, 1'b0);
		delay = 4'h2;
		go(1'b1, 6'h09, 31'h00000040, 3'h7, wd, 35'h200000000, 1'b0);
		chk("error hold", 35'h1, {34'h0, err_hold});
		clr();
		go(1'b0, 6'h09, 31'h00000060, 3'h7, 32'h0, {3'h3, lastrd}, 1'b0);
		clr();
		accept[6'h39] = 1'b0;
		go(1'b0, 6'h39, 31'h00000000, 3'h7, 32'h0, 35'h0, 1'b1);
		arst_n = 1'b0;
		@(negedge clock);
		chk("reset lines", 35'h2, {33'h0, bus_as_n, bus_d_oe});
		arst_n = 1'b1;
		go(1'b1, 6'h2D, 31'h00000004, 3'h7, wd2, 35'h0, 1'b0);
		go(1'b0, 6'h2D, 31'h00000004, 3'h7, 32'h0, {3'h1, wd2}, 1'b0);
		repeat (5) @(negedge clock);
		chk("pending", 35'h0, 35'(notes.size()));
		summarize();
	end
endmodule
